/* core/smpc_pkg.sv */
/*
 * Package for the stop-mode power controller: register indexes,
 * field positions, reset values, state type and the power-control
 * bundle. Assumes a single 50 MHz system clock domain.
 */
`default_nettype none

package smpc_pkg;

    // ======================================================
    // Register map (index on the plain register port)
    // ======================================================
    localparam logic [1:0] SMPC_IDX_CTL1 = 2'h0;  // Lowvolt reset, stop enable
    localparam logic [1:0] SMPC_IDX_CTL2 = 2'h1;  // Power-down selects, ack, flag
    localparam logic [1:0] SMPC_IDX_DBG  = 2'h2;  // Debug status/control
    localparam logic [1:0] SMPC_IDX_STAT = 2'h3;  // Current mode, read only

    // ======================================================
    // Field positions
    // ======================================================
    localparam int SMPC_B_LVRE  = 0;  // lowvolt_reset_enable
    localparam int SMPC_B_STOP_INSTR_ENABLE = 1;  // stop_instr_enable
    localparam int SMPC_B_RTIE  = 2;  // realtime_interrupt source enable
    localparam int SMPC_B_PDS   = 0;  // power_down_select
    localparam int SMPC_B_PPDS  = 1;  // partial_power_down_select
    localparam int SMPC_B_ACK   = 2;  // pin_latch_release_ack, write only
    localparam int SMPC_B_PARTIAL_POWER_DOWN_FLAG  = 3;  // partial_power_down_flag, read only
    localparam int SMPC_B_DBGE  = 0;  // debug_entry_enable
    localparam int SMPC_B_BGACT = 1;  // Active background, read only

    // ======================================================
    // Reset values
    // ======================================================
    localparam logic [2:0] SMPC_RST_CTL1 = 3'h0;
    localparam logic [1:0] SMPC_RST_CTL2 = 2'h0;
    localparam logic       SMPC_RST_DBGE = 1'h0;

    // ======================================================
    // Mode codes shown in the status register
    // ======================================================
    localparam logic [2:0] SMPC_M_RUN   = 3'h0;
    localparam logic [2:0] SMPC_M_STOP1 = 3'h1;
    localparam logic [2:0] SMPC_M_STOP2 = 3'h2;
    localparam logic [2:0] SMPC_M_STOP3 = 3'h3;
    localparam logic [2:0] SMPC_M_BKGD  = 3'h4;

    typedef enum logic [2:0] {
        SMPC_RUN, SMPC_STOP1, SMPC_STOP2, SMPC_STOP3, SMPC_BKGD
    } smpc_state_t;

    // Power and clock controls driven to the rest of the chip
    typedef struct packed {
        logic periph_clk_en;  // Timer, serial, spi, carrier clocks
        logic bdm_clk_en;     // Background debug logic clock
        logic osc_en;         // Oscillator running
        logic reg_full;       // Regulator in full regulation
        logic analog_comparator_standby;   // Analog comparator in standby
        logic pin_hold;       // Pin latches closed
        logic pin_force_rst;  // Pins forced to reset state
        logic rti_en;         // Realtime interrupt kept alive
    } smpc_pwr_t;

endpackage : smpc_pkg

`default_nettype wire

/* core/smpc_ctrl.sv */
/*
 * Stop-mode power controller: chooses the stop variant on a stop
 * instruction, gates clocks, oscillator and regulator, governs pin
 * latching and wakeup resets, and answers debug commands in stop.
 * Assumes inputs synchronous to sys_clk and a one-cycle register port.
 */
`default_nettype none

// What this block does
// [R01] Background entry from run needs debug enable
// [R02] Debug clock stays on in stop when enabled
// [R03] Regulator full regulation when debug enabled
// [R04] Debug enable forces stop3 always
// [R05] Status memory commands in stop return error
// [R06] Background command wakes stop into background
// [R07] All debug commands accepted in background
// [R08] Enabled stop3: oscillator, regulator on, realtime interrupt kept
// [R09] Lowvolt reset enable keeps regulator active
// [R10] Lowvolt reset enable turns stop1/2 into stop3
// [R11] Peripheral clocks off in every stop
// [R12] Stop3 leaves pins driven by logic
// [R13] Stop2 latches pins until release ack
// [R14] Stop1 forces pins to reset state
// [R15] Stop3 keeps registers and RAM
// [R16] Stop2 wake resets registers, keeps RAM
// [R17] Stop1 wake resets registers, RAM lost
// [R18] Oscillator off in stop unless enabled stop3
// [R19] Peripherals halted; reset after stop1/2 wake
// [R20] Comparator standby in stop; reset after stop1/2
// [R21] Keypad wake rules differ stop3 vs stop1/2
// [R22] Regulator standby unless lowvolt or debug enabled
// [R23] Power-down select bits choose the variant
// [R24] Stop disabled gives illegal-opcode reset
// [R25] Flag set after stop2 until ack written
// [R26] Selects sampled once at stop instruction

module smpc_ctrl
    import smpc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       stop_instr,
    input  wire logic [7:0] keypad_group_one_n,
    input  wire logic [7:0] keypad_group_one_en,
    input  wire logic       irq_wake_n,
    input  wire logic       keypad_int_req,
    input  wire logic       rti_wake,
    input  wire logic       dbg_cmd_valid,
    input  wire logic       dbg_cmd_background,
    input  wire logic       dbg_cmd_mem_status,
    input  wire logic       dbg_cmd_go,
    output logic            dbg_cmd_ok,
    output logic            dbg_cmd_err,
    output smpc_pwr_t       pwr,
    output logic            wake_sys_rst,
    output logic            ram_lost,
    output logic            illegal_op_rst,
    output logic            stop3_int_exit
);

    // ======================================================
    // Storage
    // ======================================================
    smpc_state_t state_r, state_nxt;
    logic [2:0]  ctl1_r;
    logic [1:0]  ctl2_r;
    logic        dbge_r;
    logic        partial_power_down_flag_r;
    logic        dbg_snap_r;   // Debug enable at stop instruction
    logic        lvre_snap_r;  // Lowvolt enable at stop instruction
    smpc_pwr_t   pwr_nxt;

    // ======================================================
    // Decode of register port and events
    // ======================================================
    wire wr_ctl1   = reg_wr && (reg_addr == SMPC_IDX_CTL1);
    wire wr_ctl2   = reg_wr && (reg_addr == SMPC_IDX_CTL2);
    wire wr_dbg    = reg_wr && (reg_addr == SMPC_IDX_DBG);
    wire ack_wr    = wr_ctl2 && reg_wdata[SMPC_B_ACK];
    wire in_run    = (state_r == SMPC_RUN);
    wire in_bkgd   = (state_r == SMPC_BKGD);
    wire in_stop   = !in_run && !in_bkgd;
    wire stop_instr_enable     = ctl1_r[SMPC_B_STOP_INSTR_ENABLE];
    wire lvre      = ctl1_r[SMPC_B_LVRE];
    wire stop_take = stop_instr && in_run && stop_instr_enable;
    wire stop_bad  = stop_instr && in_run && !stop_instr_enable;  // [R24]
    wire bg_cmd    = dbg_cmd_valid && dbg_cmd_background;
    wire ms_cmd    = dbg_cmd_valid && dbg_cmd_mem_status;

    // Keypad group one and irq wake, active low always
    wire kpd_wake  = |(~keypad_group_one_n & keypad_group_one_en);  // [R21]
    wire pin_wake  = kpd_wake || !irq_wake_n;
    wire rti_ok    = rti_wake && ctl1_r[SMPC_B_RTIE];
    // Stop3 wakes on enabled keypad interrupts as configured
    wire s3_int    = keypad_int_req || !irq_wake_n || rti_ok;  // [R21]
    wire s3_bg     = bg_cmd && dbg_snap_r;  // [R06]
    wire s1_wake   = (state_r == SMPC_STOP1) && pin_wake;
    wire s2_wake   = (state_r == SMPC_STOP2) && (pin_wake || rti_ok);
    wire full_wake = s1_wake || s2_wake;  // [R16] [R17]

    // ======================================================
    // Stop variant from one sample of the selects
    // ======================================================
    function automatic smpc_state_t pick_stop(
        input logic pds,
        input logic ppds,
        input logic dbg,
        input logic lv
    );
        smpc_state_t s;
        if (dbg || lv) begin
            s = SMPC_STOP3;  // [R04] [R10]
        end else if (pds && ppds) begin
            s = SMPC_STOP2;  // [R23]
        end else if (pds) begin
            s = SMPC_STOP1;  // [R23]
        end else begin
            s = SMPC_STOP3;
        end
        return s;
    endfunction : pick_stop

    wire smpc_state_t stop_sel = pick_stop(ctl2_r[SMPC_B_PDS],
        ctl2_r[SMPC_B_PPDS], dbge_r, lvre);  // [R26]

    // ======================================================
    // Next state
    // ======================================================
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SMPC_RUN: begin
                if (stop_take) begin
                    state_nxt = stop_sel;
                end else if (bg_cmd && dbge_r) begin
                    state_nxt = SMPC_BKGD;  // [R01]
                end
            end
            SMPC_STOP1, SMPC_STOP2: begin
                if (full_wake) begin
                    state_nxt = SMPC_RUN;
                end
            end
            SMPC_STOP3: begin
                if (s3_bg) begin
                    state_nxt = SMPC_BKGD;  // [R06]
                end else if (s3_int) begin
                    state_nxt = SMPC_RUN;  // [R15]
                end
            end
            SMPC_BKGD: begin
                if (dbg_cmd_valid && dbg_cmd_go) begin
                    state_nxt = SMPC_RUN;
                end
            end
            default: state_nxt = SMPC_RUN;
        endcase
    end

    // ======================================================
    // Power controls for the state being entered
    // ======================================================
    wire nxt_stop = (state_nxt != SMPC_RUN) && (state_nxt != SMPC_BKGD);
    wire nxt_s1   = (state_nxt == SMPC_STOP1);
    wire nxt_s2   = (state_nxt == SMPC_STOP2);
    wire snap_dbg = stop_take ? dbge_r : dbg_snap_r;
    wire snap_lv  = stop_take ? lvre : lvre_snap_r;
    wire keep_on  = snap_dbg || snap_lv;

    always_comb begin
        pwr_nxt.periph_clk_en = !nxt_stop;                  // [R11] [R19]
        pwr_nxt.bdm_clk_en    = !nxt_stop || snap_dbg;      // [R02]
        pwr_nxt.osc_en        = !nxt_stop || keep_on;       // [R18] [R08]
        pwr_nxt.reg_full      = !nxt_stop || keep_on;       // [R03] [R09] [R22]
        pwr_nxt.analog_comparator_standby  = nxt_stop;                   // [R20]
        // Latch stays closed after stop2 until the ack
        pwr_nxt.pin_hold      = nxt_s2 || (partial_power_down_flag_r && !ack_wr)
                                || (s2_wake && full_wake);  // [R13] [R25]
        pwr_nxt.pin_force_rst = nxt_s1;                     // [R14] [R12]
        // Wake from stop1/2 clears the enable along with the registers
        pwr_nxt.rti_en        = ctl1_r[SMPC_B_RTIE] && !nxt_s1 && !full_wake;  // [R08]
    end

    // ======================================================
    // State and power register
    // ======================================================
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= SMPC_RUN;
            pwr     <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        end else if (ce) begin
            state_r <= state_nxt;
            pwr     <= pwr_nxt;
        end
    end

    // Debug and lowvolt enables frozen at the stop instruction
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dbg_snap_r  <= 1'b0;
            lvre_snap_r <= 1'b0;
        end else if (ce && stop_take) begin
            dbg_snap_r  <= dbge_r;  // [R26]
            lvre_snap_r <= lvre;    // [R26]
        end
    end

    // ======================================================
    // Software registers; stop1/2 wake returns them to reset
    // ======================================================
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctl1_r <= SMPC_RST_CTL1;
            ctl2_r <= SMPC_RST_CTL2;
            dbge_r <= SMPC_RST_DBGE;
        end else if (ce) begin
            if (full_wake) begin
                ctl1_r <= SMPC_RST_CTL1;  // [R16] [R17]
                ctl2_r <= SMPC_RST_CTL2;
                dbge_r <= SMPC_RST_DBGE;
            end else begin
                if (wr_ctl1) begin
                    ctl1_r <= reg_wdata[2:0];
                end
                if (wr_ctl2) begin
                    ctl2_r <= reg_wdata[1:0];
                end
                if (wr_dbg) begin
                    dbge_r <= reg_wdata[SMPC_B_DBGE];
                end
            end
        end
    end

    // Partial power-down flag: set wins over the ack
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            partial_power_down_flag_r <= 1'b0;
        end else if (ce) begin
            if (s2_wake) begin
                partial_power_down_flag_r <= 1'b1;  // [R25]
            end else if (ack_wr) begin
                partial_power_down_flag_r <= 1'b0;  // [R25]
            end
        end
    end

    // ======================================================
    // Read data, one cycle after the strobe
    // ======================================================
    wire [2:0] mode_code =
        (state_r == SMPC_STOP1) ? SMPC_M_STOP1 :
        (state_r == SMPC_STOP2) ? SMPC_M_STOP2 :
        (state_r == SMPC_STOP3) ? SMPC_M_STOP3 :
        in_bkgd                 ? SMPC_M_BKGD  : SMPC_M_RUN;
    wire [7:0] rd_mux =
        (reg_addr == SMPC_IDX_CTL1) ? {5'h00, ctl1_r} :
        (reg_addr == SMPC_IDX_CTL2) ? {4'h0, partial_power_down_flag_r, 1'b0, ctl2_r} :
        (reg_addr == SMPC_IDX_DBG)  ? {6'h00, in_bkgd, dbge_r} :
                                      {5'h00, mode_code};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ======================================================
    // Debug command answers and reset pulses
    // ======================================================
    wire cmd_ok_nxt  = dbg_cmd_valid && (in_bkgd                        // [R07]
                       || (in_run && !dbg_cmd_go)
                       || (in_stop && bg_cmd && dbg_snap_r));
    wire cmd_err_nxt = ms_cmd && in_stop;  // [R05]

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dbg_cmd_ok     <= 1'b0;
            dbg_cmd_err    <= 1'b0;
            wake_sys_rst   <= 1'b0;
            ram_lost       <= 1'b0;
            illegal_op_rst <= 1'b0;
            stop3_int_exit <= 1'b0;
        end else if (ce) begin
            dbg_cmd_ok     <= cmd_ok_nxt && !cmd_err_nxt;
            dbg_cmd_err    <= cmd_err_nxt;
            wake_sys_rst   <= full_wake;          // [R19] [R20]
            ram_lost       <= s1_wake;            // [R17]
            illegal_op_rst <= stop_bad;           // [R24]
            stop3_int_exit <= (state_r == SMPC_STOP3) && s3_int && !s3_bg;
        end
    end

    // ======================================================
    // Checks
    // ======================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_illegal_stop: assert property (  // [R24]
        ce && stop_bad |=> illegal_op_rst && state_r == SMPC_RUN)
        else $error("stop without enable did not reset");
    a_debug_forces_s3: assert property (  // [R04]
        ce && stop_take && dbge_r |=> state_r == SMPC_STOP3)
        else $error("debug enabled stop not stop3");
    a_lowvolt_forces_s3: assert property (  // [R10]
        ce && stop_take && lvre |=> state_r == SMPC_STOP3)
        else $error("lowvolt enabled stop not stop3");
    a_stop_select_s1: assert property (  // [R23]
        ce && stop_take && !dbge_r && !lvre && ctl2_r == 2'h1
        |=> state_r == SMPC_STOP1 && pwr.pin_force_rst)
        else $error("stop1 select not honoured");
    a_debug_clock_alive: assert property (  // [R02]
        in_stop && dbg_snap_r |-> pwr.bdm_clk_en && pwr.reg_full && pwr.osc_en)
        else $error("debug clock or regulator dropped in stop");
    a_periph_clk_off: assert property (  // [R11]
        in_stop |-> !pwr.periph_clk_en && pwr.analog_comparator_standby)
        else $error("peripheral clock running in stop");
    a_regulator_standby: assert property (  // [R22]
        in_stop && !dbg_snap_r && !lvre_snap_r |-> !pwr.reg_full && !pwr.osc_en)
        else $error("regulator not in standby");
    a_flag_holds_pins: assert property (  // [R25]
        partial_power_down_flag_r |-> pwr.pin_hold)
        else $error("pins released while flag set");
    a_stop2_wake: assert property (  // [R16]
        ce && s2_wake |=> partial_power_down_flag_r && wake_sys_rst && state_r == SMPC_RUN)
        else $error("stop2 wake sequence wrong");
    a_mem_status_err: assert property (  // [R05]
        ce && ms_cmd && in_stop |=> dbg_cmd_err && !dbg_cmd_ok)
        else $error("status command in stop not refused");
    a_bg_wake: assert property (  // [R06]
        ce && in_stop && s3_bg |=> in_bkgd ##1 !pwr.analog_comparator_standby [*1])
        else $error("background command did not wake");

    c_stop1_round: cover property (
        ce && state_r == SMPC_STOP1 ##[1:50] wake_sys_rst);
    c_stop2_ack: cover property (partial_power_down_flag_r ##[1:50] !partial_power_down_flag_r);
    c_stop3_bg: cover property (state_r == SMPC_STOP3 ##1 in_bkgd);
    c_illegal: cover property (illegal_op_rst);

endmodule : smpc_ctrl

`default_nettype wire

/* testbench/smpc_host_model.sv */
/*
 * Far-side model: debug host command strobes and the wakeup sources
 * (keypad pins, irq pin, keypad interrupt, realtime interrupt).
 * Assumes its tasks are called from the bench, one at a time.
 */
`default_nettype none

module smpc_host_model (
    input  wire logic       sys_clk,
    output logic      [7:0] keypad_group_one_n,
    output logic      [7:0] keypad_group_one_en,
    output logic            irq_wake_n,
    output logic            keypad_int_req,
    output logic            rti_wake,
    output logic            dbg_cmd_valid,
    output logic            dbg_cmd_background,
    output logic            dbg_cmd_mem_status,
    output logic            dbg_cmd_go
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels: pins pulled up, no events, no command
    initial begin
        keypad_group_one_n  = 8'hFF;
        keypad_group_one_en = 8'h00;
        irq_wake_n          = 1'b1;
        keypad_int_req      = 1'b0;
        rti_wake            = 1'b0;
        dbg_cmd_valid       = 1'b0;
        dbg_cmd_background  = 1'b0;
        dbg_cmd_mem_status  = 1'b0;
        dbg_cmd_go          = 1'b0;
    end

    // ======================================================
    // Debug host
    // ======================================================
    // One-cycle command strobe, background allowed in stop
    task automatic cmd(input logic bg, input logic ms, input logic go);
        @(posedge sys_clk);
        dbg_cmd_valid      <= 1'b1;
        dbg_cmd_background <= bg;
        dbg_cmd_mem_status <= ms;
        dbg_cmd_go         <= go;
        @(posedge sys_clk);
        dbg_cmd_valid      <= 1'b0;
        dbg_cmd_background <= 1'b0;
        dbg_cmd_mem_status <= 1'b0;
        dbg_cmd_go         <= 1'b0;
    endtask : cmd

    // ======================================================
    // Wakeup sources
    // ======================================================
    // Pin enables held as levels
    task automatic set_en(input logic [7:0] v);
        @(posedge sys_clk);
        keypad_group_one_en <= v;
    endtask : set_en

    // One-cycle wake event; pins pulled back high afterwards
    task automatic wake(input int src, input int idx);
        @(posedge sys_clk);
        case (src)
            0: keypad_group_one_n[idx] <= 1'b0;
            1: irq_wake_n <= 1'b0;
            2: keypad_int_req <= 1'b1;
            default: rti_wake <= 1'b1;
        endcase
        @(posedge sys_clk);
        keypad_group_one_n <= 8'hFF;
        irq_wake_n         <= 1'b1;
        keypad_int_req     <= 1'b0;
        rti_wake           <= 1'b0;
    endtask : wake

endmodule : smpc_host_model

`default_nettype wire

/* testbench/stop_mode_power_control_bench.sv */
/*
 * Self-checking bench for the stop-mode power controller: register
 * port, stop instruction and far-side model, checked against an
 * integer model. Assumes core/ package and design compiled first.
 */
`default_nettype none

module stop_mode_power_control_bench
    import smpc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk, nrst, ce, reg_wr, reg_rd, stop_instr;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, kp_n, kp_en, en;
    logic       irq_n, kreq, realtime_interrupt, c_v, c_bg, c_ms, c_go, c_ok, c_err;
    logic       wrst, rlost, illop, s3exit;
    smpc_pwr_t  pwr;
    int         lv, stop_instr_enable, rtie, pds, ppds, partial_power_down_flag, dbge, mode;
    int         mismatches, tests_run, seed, idx, dis;

    smpc_ctrl i_dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .stop_instr(stop_instr), .keypad_group_one_n(kp_n), .keypad_group_one_en(kp_en),
        .irq_wake_n(irq_n), .keypad_int_req(kreq), .rti_wake(realtime_interrupt), .dbg_cmd_valid(c_v),
        .dbg_cmd_background(c_bg), .dbg_cmd_mem_status(c_ms), .dbg_cmd_go(c_go),
        .dbg_cmd_ok(c_ok), .dbg_cmd_err(c_err), .pwr(pwr), .wake_sys_rst(wrst),
        .ram_lost(rlost), .illegal_op_rst(illop), .stop3_int_exit(s3exit));

    smpc_host_model i_host (.sys_clk(sys_clk), .keypad_group_one_n(kp_n),
        .keypad_group_one_en(kp_en), .irq_wake_n(irq_n), .keypad_int_req(kreq),
        .rti_wake(realtime_interrupt), .dbg_cmd_valid(c_v), .dbg_cmd_background(c_bg),
        .dbg_cmd_mem_status(c_ms), .dbg_cmd_go(c_go));

    // 50 MHz clock
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    // ======================================================
    // Model and compares
    // ======================================================
    // Expected power bundle for a mode code
    function automatic logic [7:0] exp_pwr(input int m);
        case (m)
            1: return 8'h0A;
            2: return 8'h0C | 8'(rtie);
            3: return 8'h08 | 8'(rtie) | (dbge != 0 ? 8'h70 : lv != 0 ? 8'h30 : 8'h00);
            default: return (partial_power_down_flag != 0 ? 8'hF4 : 8'hF0) | 8'(rtie);
        endcase
    endfunction : exp_pwr

    // Expected register contents
    function automatic logic [7:0] exp_reg(input int a);
        case (a)
            0: return 8'(rtie * 4 + stop_instr_enable * 2 + lv);
            1: return 8'(partial_power_down_flag * 8 + ppds * 2 + pds);
            2: return 8'((mode == 4) * 2 + dbge);
            default: return 8'(mode);
        endcase
    endfunction : exp_reg

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk_byte

    task automatic chk_flag(input logic got, input logic exp, input string msg);
        chk_byte({7'h00, got}, {7'h00, exp}, msg);
    endtask : chk_flag

    // ======================================================
    // Drivers
    // ======================================================
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        if (a == 2'h0) begin
            lv    = d[0];
            stop_instr_enable = d[1];
            rtie  = d[2];
        end
        if (a == 2'h1) begin
            pds  = d[0];
            ppds = d[1];
            if (d[2]) partial_power_down_flag = 0;
        end
        if (a == 2'h2) dbge = d[0];
    endtask : wr

    task automatic rd(input logic [1:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk_byte(reg_rdata, exp_reg(a), "read data");
    endtask : rd

    task automatic do_stop();
        @(posedge sys_clk);
        stop_instr <= 1'b1;
        @(posedge sys_clk);
        stop_instr <= 1'b0;
        if (stop_instr_enable != 0) mode = (pds == 0 || dbge != 0 || lv != 0) ? 3 : ppds != 0 ? 2 : 1;
        #1;
        chk_flag(illop, stop_instr_enable == 0, "illegal opcode reset");
        chk_byte(pwr, exp_pwr(mode), "pwr after stop");
    endtask : do_stop

    task automatic wake(input int src, input int i);
        i_host.wake(src, i);
        #1;
        chk_flag(wrst, mode == 1 || mode == 2, "wake reset");
        chk_flag(rlost, mode == 1, "ram lost");
        chk_flag(s3exit, mode == 3, "stop3 exit");
        if (mode != 3) begin
            {lv, stop_instr_enable, rtie, pds, ppds, dbge} = '0;
            if (mode == 2) partial_power_down_flag = 1;
        end
        mode = 0;
        chk_byte(pwr, exp_pwr(0), "pwr after wake");
    endtask : wake

    // Kind 0 background, 1 status memory access, 2 go
    task automatic dbg(input int kind);
        logic ok, err;
        ok  = kind == 2 ? mode == 4 : mode == 0 || mode == 4 || (kind == 0 && dbge != 0);
        err = kind == 1 && mode != 0 && mode != 4;
        i_host.cmd(kind == 0, kind == 1, kind == 2);
        #1;
        if (ok) mode = kind == 0 ? (dbge != 0 ? 4 : mode) : kind == 2 ? 0 : mode;
        chk_flag(c_ok, ok, "command ok");
        chk_flag(c_err, err, "command error");
    endtask : dbg

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict();
    end

    // ======================================================
    // Main sequence
    // ======================================================
    initial begin
        {reg_wr, reg_rd, stop_instr, reg_addr, reg_wdata} = '0;
        {lv, stop_instr_enable, rtie, pds, ppds, partial_power_down_flag, dbge, mode, mismatches, tests_run} = '0;
        nrst = 1'b0;
        ce   = 1'b1;
        seed = 32'haf63;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        chk_byte(pwr, 8'hF0, "reset pwr");
        for (int a = 0; a < 4; a++) rd(2'(a));
        do_stop();
        rd(2'h3);
        $display("test reset_illegal done");
        // Stop1 then stop2, with a disabled pin that must not wake
        for (int s = 1; s <= 3; s += 2) begin
            idx = $random(seed) & 7;
            dis = (idx + 5) & 7;
            en  = (8'($random(seed)) | (8'h01 << idx)) & ~(8'h01 << dis);
            i_host.set_en(en);
            wr(2'h0, 8'h02 | 8'(($random(seed) & 1) << 2));
            wr(2'h1, 8'(s));
            do_stop();
            rd(2'h3);
            i_host.wake(0, dis);
            #1;
            chk_flag(wrst, 1'b0, "disabled pin woke");
            wake(0, idx);
            rd(2'h1);
            rd(2'h0);
            wr(2'h1, 8'h04);
            rd(2'h1);
            chk_byte(pwr, exp_pwr(0), "pins released");
        end
        $display("test stop1_stop2 done");
        // Stop3 by lowvolt override and by select, each wake source
        for (int i = 0; i < 4; i++) begin
            wr(2'h0, 8'h06 | 8'(i < 3));
            wr(2'h1, i == 0 ? 8'h01 : i == 1 ? 8'h03 : 8'h00);
            do_stop();
            rd(2'h3);
            wake(i % 3 + 1, 0);
            rd(2'h0);
            rd(2'h1);
        end
        $display("test stop3 done");
        // Debug enable in stop and background entry
        wr(2'h0, 8'h02);
        dbg(0);
        wr(2'h2, 8'h01);
        for (int s = 0; s < 2; s++) begin
            wr(2'h1, s != 0 ? 8'h03 : 8'h01);
            do_stop();
            dbg(1);
            dbg(2);
            dbg(0);
            chk_byte(pwr, exp_pwr(mode), "pwr in background");
            rd(2'h2);
            dbg(1);
            dbg(2);
            rd(2'h3);
        end
        dbg(0);
        dbg(2);
        $display("test debug done");
        print_verdict();
    end

endmodule : stop_mode_power_control_bench

`default_nettype wire
